/* include/vrm_pkg.sv */
// Constants and enumerations shared by the vector real multiplier files.
// Assumes operands arrive as packed lanes of fixed-point words on one clock.
// -----------------------------------------------------------------------------
// Functional notes
// - Each lane output is the product of its two lane inputs.
// - All parallel_sample_factor lanes are multiplied in parallel every sample period.
// - Full precision output is wide enough to hold the exact product.
// - Floating-point results would always be full precision; reduction is fixed-point only.
// - User precision gives configured signedness, width and binary point.
// - Output lags its inputs by exactly the latency setting in sample periods; here the input FIFO adds one more period.
// - With rounding or saturation, first register sits right after that logic.
// - Core gets registers up to its optimum depth; the rest follow rounding.
// - Without rounding or saturation logic, every register pipelines the core.
// - An enable input controls whether the block advances; here the input FIFO still takes words while it is low.
// - Overflow either saturates to the range limits or wraps; flag equals wrap.
// - Quantisation truncates, rounds half away from zero, or rounds half to even.
// -----------------------------------------------------------------------------
package vrm_pkg;
   // Lane count and operand formats
   localparam int VRM_PARALLEL_SAMPLE_FACTOR = 4;
   localparam int VRM_A_W = 16;
   localparam int VRM_B_W = 16;
   localparam int VRM_A_BP = 8;
   localparam int VRM_B_BP = 8;
   // User-defined output format
   localparam int VRM_OUT_W = 16;
   localparam int VRM_OUT_BP = 8;
   // Pipeline shape
   localparam int VRM_LATENCY = 3;
   localparam int VRM_CORE_OPT = 2;
   localparam int VRM_FIFO_DEPTH = 8;
   // Reset value of every multiplier pipeline register; the FIFO resets its own registers to zero, except ready, which resets to one
   localparam logic VRM_RST_VAL = 1'b0;

   // Quantisation modes
   typedef enum logic [2:0] {
      VRM_Q_TRUNC = 3'h1,
      VRM_Q_RND_INF = 3'h2,
      VRM_Q_RND_EVEN = 3'h4
   } vrm_quant_e;

   // Overflow modes; the flag mode builds the same logic as wrap
   typedef enum logic [2:0] {
      VRM_O_WRAP = 3'h1,
      VRM_O_SAT = 3'h2,
      VRM_O_FLAG = 3'h4
   } vrm_ovf_e;
endpackage

/* rtl/vrm_fifo.sv */
// Input buffer for the multiplier: a synchronous FIFO of operand words.
// Assumes both sides run on the same clock; depth must be a power of two.
`timescale 1ns/1ns
module vrm_fifo #(
   parameter int W = 8,
   parameter int DEPTH = vrm_pkg::VRM_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Fill side
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready
);
   import vrm_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // -------------------------------------------------------------------------
   // Configuration check
   // -------------------------------------------------------------------------
   if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0) || (W < 1)) begin : g_bad
      $error("vrm_fifo: DEPTH must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic rdy;
   } vrm_fifo_s;

   vrm_fifo_s st_r;
   vrm_fifo_s st_nxt;
   logic push;
   logic pop;

   // Handshakes; ready is registered so the top port comes from a flop
   assign push = i_valid & st_r.rdy;
   assign pop = i_ready & (st_r.cnt != '0);
   assign o_ready = st_r.rdy;
   assign o_valid = (st_r.cnt != '0);
   assign o_data = st_r.mem[st_r.rd];

   // Next state: write, read, occupancy
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr] = i_data;
         st_nxt.wr = st_r.wr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd = st_r.rd + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      st_nxt.rdy = (st_nxt.cnt != (AW+1)'(DEPTH));
   end

   // State register; comes out of reset ready
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '{default: '0, rdy: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   property p_fifo_full;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (st_r.cnt == (AW+1)'(DEPTH)) |-> !o_ready;
   endproperty
   a_fifo_full: assert property (p_fifo_full) else $error("fifo ready while full");

   property p_fifo_cnt;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (push && !pop) |=> (st_r.cnt == $past(st_r.cnt) + 1'b1);
   endproperty
   a_fifo_cnt: assert property (p_fifo_cnt) else $error("fifo count did not rise on push");
endmodule

/* rtl/vrm_mult.sv */
// Vector real multiplier: lane-wise fixed-point products with a latency pipeline.
// Assumes operand and result logic sit on the same clock as this block.
`timescale 1ns/1ns
module vrm_mult #(
   parameter int LANES = vrm_pkg::VRM_PARALLEL_SAMPLE_FACTOR,
   parameter int A_W = vrm_pkg::VRM_A_W,
   parameter int B_W = vrm_pkg::VRM_B_W,
   parameter int A_BP = vrm_pkg::VRM_A_BP,
   parameter int B_BP = vrm_pkg::VRM_B_BP,
   parameter bit IN_SIGNED = 1'b1,
   parameter bit FULL = 1'b0,
   parameter bit OUT_SIGNED = 1'b1,
   parameter int OUT_W = vrm_pkg::VRM_OUT_W,
   parameter int OUT_BP = vrm_pkg::VRM_OUT_BP,
   parameter vrm_pkg::vrm_quant_e QUANT = vrm_pkg::VRM_Q_RND_EVEN,
   parameter vrm_pkg::vrm_ovf_e OVF = vrm_pkg::VRM_O_SAT,
   parameter int LATENCY = vrm_pkg::VRM_LATENCY,
   parameter int CORE_OPT = vrm_pkg::VRM_CORE_OPT,
   parameter int FIFO_DEPTH = vrm_pkg::VRM_FIFO_DEPTH,
   localparam int PW = A_W + B_W,
   localparam int OW = FULL ? PW : OUT_W
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Advance control
   input wire logic i_en,
   // Operand stream
   input wire logic i_valid,
   input wire logic [LANES*A_W-1:0] i_a,
   input wire logic [LANES*B_W-1:0] i_b,
   output logic o_ready,
   // Product stream
   output logic o_valid,
   output logic [LANES*OW-1:0] o_prod,
   input wire logic i_ready
);
   import vrm_pkg::*;

   // -------------------------------------------------------------------------
   // Derived shape
   // -------------------------------------------------------------------------
   localparam int PBP = A_BP + B_BP;
   localparam int D = FULL ? 0 : (PBP - OUT_BP);
   localparam int DS = (D > 0) ? D : 1;
   localparam int EW = PW + 2;
   localparam bit OVF_SAT = (OVF == VRM_O_SAT);
   localparam bit NEED_RQ = !FULL && (((D > 0) && (QUANT != VRM_Q_TRUNC)) ||
      (OVF_SAT && (((OW - OUT_BP) != (PW - PBP)) || (OUT_SIGNED != IN_SIGNED))));
   localparam int C = NEED_RQ ? (((LATENCY - 1) < CORE_OPT) ? (LATENCY - 1) : CORE_OPT) : LATENCY;
   localparam int R = LATENCY - C;
   localparam int CM = (C > 0) ? C : 1;
   localparam int RM = (R > 0) ? R : 1;
   localparam int FW = LANES * (A_W + B_W);
   localparam logic signed [EW-1:0] HALF = EW'(1) << (DS - 1);
   localparam logic signed [EW-1:0] MAXV = OUT_SIGNED ? ((EW'(1) << (OW - 1)) - EW'(1)) : ((EW'(1) << OW) - EW'(1));
   localparam logic signed [EW-1:0] MINV = OUT_SIGNED ? -(EW'(1) << (OW - 1)) : EW'(0);

   // Floating point is not built here, so only fixed-point formats pass
   if ((LANES < 1) || (LATENCY < 1) || (CORE_OPT < 0) || (D < 0) || (OW > PW) || (OW < 1)) begin : g_bad
      $error("vrm_mult: latency, lane count or output format cannot be served");
   end

   // -------------------------------------------------------------------------
   // Arithmetic functions
   // -------------------------------------------------------------------------
   // Exact product: operands extended to PW, so the product fits with no loss
   function automatic logic [PW-1:0] f_mul(input logic [A_W-1:0] a, input logic [B_W-1:0] b);
      logic [PW-1:0] sa;
      logic [PW-1:0] sb;
      sa = {{B_W{IN_SIGNED & a[A_W-1]}}, a};
      sb = {{A_W{IN_SIGNED & b[B_W-1]}}, b};
      f_mul = sa * sb;
   endfunction

   // Drop D fraction bits by the chosen quantisation mode
   function automatic logic signed [EW-1:0] f_rnd(input logic [PW-1:0] p);
      logic signed [EW-1:0] x;
      logic signed [EW-1:0] adj;
      x = {{2{IN_SIGNED & p[PW-1]}}, p};
      adj = '0;
      if (D > 0) begin
         case (QUANT)
            VRM_Q_RND_INF: adj = HALF - {{(EW-1){1'b0}}, x[EW-1]};
            VRM_Q_RND_EVEN: adj = HALF - EW'(1) + {{(EW-1){1'b0}}, x[DS]};
            default: adj = '0;
         endcase
      end
      f_rnd = (x + adj) >>> D;
   endfunction

   // Fit the rounded value to the output width
   function automatic logic [OW-1:0] f_fit(input logic [PW-1:0] p);
      logic signed [EW-1:0] q;
      q = f_rnd(p);
      if (OVF_SAT && (q > MAXV)) begin
         q = MAXV;
      end else if (OVF_SAT && (q < MINV)) begin
         q = MINV;
      end
      f_fit = q[OW-1:0];
   endfunction

   // -------------------------------------------------------------------------
   // State and datapath
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [CM-1:0] cv;
      logic [CM-1:0][LANES-1:0][PW-1:0] cd;
      logic [RM-1:0] pv;
      logic [RM-1:0][LANES-1:0][OW-1:0] pd;
   } vrm_state_s;

   vrm_state_s st_r;
   vrm_state_s st_nxt;
   logic adv;
   logic f_valid;
   logic [FW-1:0] f_data;
   logic [LANES-1:0][PW-1:0] prod_in;
   logic [LANES-1:0][PW-1:0] core_tail;
   logic core_tail_v;
   logic [LANES-1:0][OW-1:0] out_w;

   // The whole pipe moves as one, so a stalled result never gets overwritten
   assign adv = i_en & (~o_valid | i_ready);

   vrm_fifo #(
      .W(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_valid(i_valid),
      .i_data({i_a, i_b}),
      .o_ready(o_ready),
      .o_valid(f_valid),
      .o_data(f_data),
      .i_ready(adv)
   );

   // One multiplier per lane, all in the same cycle
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign prod_in[l] = f_mul(f_data[LANES*B_W + l*A_W +: A_W], f_data[l*B_W +: B_W]);
   end

   // Core depth C feeds the fitting logic; with no core registers it sees the raw product
   if (C > 0) begin : g_core_tail
      assign core_tail = st_r.cd[C-1];
      assign core_tail_v = st_r.cv[C-1];
   end else begin : g_core_none
      assign core_tail = prod_in;
      assign core_tail_v = f_valid;
   end

   // Next state: shift core, then fit, then the post registers
   always_comb begin
      st_nxt = st_r;
      if (adv) begin
         for (int k = CM - 1; k > 0; k--) begin
            st_nxt.cv[k] = st_r.cv[k-1];
            st_nxt.cd[k] = st_r.cd[k-1];
         end
         st_nxt.cv[0] = f_valid;
         st_nxt.cd[0] = prod_in;
         for (int k = RM - 1; k > 0; k--) begin
            st_nxt.pv[k] = st_r.pv[k-1];
            st_nxt.pd[k] = st_r.pd[k-1];
         end
         // First post register right after rounding and saturation
         st_nxt.pv[0] = core_tail_v;
         for (int l = 0; l < LANES; l++) begin
            st_nxt.pd[0][l] = f_fit(core_tail[l]);
         end
      end
   end

   // Pipeline register
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= vrm_state_s'({$bits(vrm_state_s){VRM_RST_VAL}});
      end else begin
         st_r <= st_nxt;
      end
   end

   // Output tap after exactly LATENCY registers; with no fitting logic the
   // last core register drives the pins through wiring only
   if (R > 0) begin : g_out_post
      assign out_w = st_r.pd[R-1];
      assign o_valid = st_r.pv[R-1];
   end else begin : g_out_core
      for (genvar l = 0; l < LANES; l++) begin : g_fit
         assign out_w[l] = f_fit(st_r.cd[C-1][l]);
      end
      assign o_valid = st_r.cv[C-1];
   end
   assign o_prod = out_w;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   // Reference delay line of exact products, stepped by the same advance
   logic [LATENCY-1:0] mv_r;
   logic [LATENCY-1:0][LANES-1:0][PW-1:0] md_r;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mv_r <= '0;
         md_r <= '0;
      end else if (adv) begin
         for (int k = LATENCY - 1; k > 0; k--) begin
            mv_r[k] <= mv_r[k-1];
            md_r[k] <= md_r[k-1];
         end
         mv_r[0] <= f_valid;
         md_r[0] <= prod_in;
      end
   end

   sequence s_stall;
      o_valid && !i_ready;
   endsequence

   sequence s_idle;
      !i_en;
   endsequence

   property p_hold;
      @(posedge i_mclk) disable iff (!i_rst_b)
      s_idle |=> $stable(o_prod) && $stable(o_valid) && $stable(st_r);
   endproperty
   a_hold: assert property (p_hold) else $error("pipeline moved while disabled");

   property p_en;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (!i_en && f_valid) |=> f_valid && $stable(f_data);
   endproperty
   a_en: assert property (p_en) else $error("operand popped without enable");

   property p_stall;
      @(posedge i_mclk) disable iff (!i_rst_b)
      s_stall |=> o_valid && $stable(o_prod);
   endproperty
   a_stall: assert property (p_stall) else $error("held result lost");

   property p_lat;
      @(posedge i_mclk) disable iff (!i_rst_b)
      o_valid == mv_r[LATENCY-1];
   endproperty
   a_lat: assert property (p_lat) else $error("output valid at wrong latency");

   property p_model;
      @(posedge i_mclk) disable iff (!i_rst_b)
      o_valid |-> (out_w[LANES-1] == f_fit(md_r[LATENCY-1][LANES-1])) && (out_w[0] == f_fit(md_r[LATENCY-1][0]));
   endproperty
   a_model: assert property (p_model) else $error("lane product mismatch");

   property p_full;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (FULL && o_valid) |-> (out_w[0] == OW'(md_r[LATENCY-1][0]));
   endproperty
   a_full: assert property (p_full) else $error("full precision product not exact");

   property p_sat;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (OVF_SAT && o_valid && (f_rnd(md_r[LATENCY-1][0]) > MAXV)) |-> (out_w[0] == MAXV[OW-1:0]);
   endproperty
   a_sat: assert property (p_sat) else $error("overflow not saturated");

   property p_even;
      @(posedge i_mclk) disable iff (!i_rst_b)
      ((QUANT == VRM_Q_RND_EVEN) && (D > 0) && o_valid && (md_r[LATENCY-1][0][DS-1:0] == HALF[DS-1:0]) &&
       (f_rnd(md_r[LATENCY-1][0]) <= MAXV) && (f_rnd(md_r[LATENCY-1][0]) >= MINV)) |-> !out_w[0][0];
   endproperty
   a_even: assert property (p_even) else $error("midpoint not rounded to even");
endmodule

/* sim/test_vector_real_multiplier.sv */
// Self-checking bench for the vector real multiplier at its default formats.
// Assumes 4 lanes of signed Q7.8, output Q7.8, round to even, saturate, latency 3;
// a second copy rounds half away from zero and wraps, fed the same stream.
`timescale 1ns/1ns
module test_vector_real_multiplier;
   import vrm_pkg::*;
   localparam int AW = VRM_PARALLEL_SAMPLE_FACTOR * VRM_A_W;
   localparam int OW = VRM_PARALLEL_SAMPLE_FACTOR * VRM_OUT_W;

   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic en = 1'b1;
   logic valid = 1'b0;
   logic [AW-1:0] a = '0;
   logic [AW-1:0] b = '0;
   logic in_ready;
   logic out_valid;
   logic [OW-1:0] prod;
   logic sink_ready;
   logic [1:0] mode = 2'h0;
   int num_errors = 0;
   int comparisons = 0;
   logic [OW-1:0] exp_q[$];
   logic alt_valid;
   logic [OW-1:0] alt_prod;
   logic [OW-1:0] alt_q[$];
   logic [OW-1:0] alt_got[$];

   always #25 mclk = ~mclk;

   vrm_mult uut (.i_mclk(mclk), .i_rst_b(rst_b), .i_en(en), .i_valid(valid), .i_a(a), .i_b(b),
      .o_ready(in_ready), .o_valid(out_valid), .o_prod(prod), .i_ready(sink_ready));

   vrm_sink_model #(.W(OW)) sink (.i_mclk(mclk), .i_rst_b(rst_b), .i_en(en), .i_valid(out_valid),
      .i_data(prod), .o_ready(sink_ready), .i_mode(mode));

   // Same stream, other rounding and overflow modes; its pipe moves in step with uut
   vrm_mult #(.QUANT(VRM_Q_RND_INF), .OVF(VRM_O_WRAP)) uut_alt (.i_mclk(mclk), .i_rst_b(rst_b),
      .i_en(en), .i_valid(valid), .i_a(a), .i_b(b), .o_ready(), .o_valid(alt_valid),
      .o_prod(alt_prod), .i_ready(sink_ready));

   // Collect the second copy's products on the same advances the sink takes
   always @(posedge mclk) begin
      if (rst_b && en && alt_valid && sink_ready) begin
         alt_got.push_back(alt_prod);
      end
   end

   // ----------------------------------------
   // Reference arithmetic and checks
   // ----------------------------------------
   // Q15.16 product to Q7.8: half to even, then clamp to the signed range
   // With alt set: half away from zero, then wrap to the low 16 bits
   function automatic logic [15:0] fit(input logic [15:0] x, input logic [15:0] y, input bit alt);
      longint p;
      longint q;
      longint r;
      p = longint'($signed(x)) * longint'($signed(y));
      q = p >>> 8;
      r = p & 64'shFF;
      if (alt) begin
         if (r > 64'sh80 || (r == 64'sh80 && p >= 0)) q = q + 1;
         return q[15:0];
      end
      if (r > 64'sh80 || (r == 64'sh80 && q[0])) q = q + 1;
      if (q > 64'sh7FFF) q = 64'sh7FFF;
      if (q < -64'sh8000) q = -64'sh8000;
      return q[15:0];
   endfunction

   task automatic check_word(input logic [OW-1:0] got, input logic [OW-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_word({{(OW-1){1'b0}}, got}, {{(OW-1){1'b0}}, exp});
   endtask

   task automatic expect_word(input logic [AW-1:0] wa, input logic [AW-1:0] wb);
      logic [OW-1:0] e;
      logic [OW-1:0] e_alt;
      for (int l = 0; l < VRM_PARALLEL_SAMPLE_FACTOR; l++) begin
         e[l*16 +: 16] = fit(wa[l*16 +: 16], wb[l*16 +: 16], 1'b0);
         e_alt[l*16 +: 16] = fit(wa[l*16 +: 16], wb[l*16 +: 16], 1'b1);
      end
      exp_q.push_back(e);
      alt_q.push_back(e_alt);
   endtask

   // Offer one word and hold it until the buffer has room; ready is read between edges
   task automatic push(input logic [AW-1:0] wa, input logic [AW-1:0] wb);
      expect_word(wa, wb);
      @(negedge mclk);
      valid = 1'b1;
      a = wa;
      b = wb;
      while (in_ready !== 1'b1) @(negedge mclk);
      @(posedge mclk);
   endtask

   task automatic idle();
      @(negedge mclk);
      valid = 1'b0;
   endtask

   // Wait for every expected product, then compare in order
   task automatic drain();
      int n;
      n = 0;
      while ((sink.got.size() < exp_q.size() || alt_got.size() < alt_q.size()) && n < 2000) begin
         @(negedge mclk);
         n++;
      end
      check_bit(sink.got.size() == exp_q.size(), 1'b1);
      while (exp_q.size() > 0 && sink.got.size() > 0) begin
         check_word(sink.got.pop_front(), exp_q.pop_front());
      end
      exp_q.delete();
      check_bit(alt_got.size() == alt_q.size(), 1'b1);
      while (alt_q.size() > 0 && alt_got.size() > 0) begin
         check_word(alt_got.pop_front(), alt_q.pop_front());
      end
      alt_q.delete();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // A lone word shows up exactly three edges after its store edge
   task automatic t_latency();
      mode = 2'h0;
      push(64'h0003_0001_0100_0180, 64'h0080_0080_0200_0200);
      @(negedge mclk);
      valid = 1'b0;
      // Looked at after the store edge and the two edges that follow it
      for (int k = 1; k <= 3; k++) begin
         check_bit(out_valid, 1'b0);
         @(negedge mclk);
      end
      check_bit(out_valid, 1'b1);
      @(negedge mclk);
      check_bit(out_valid, 1'b0);
      drain();
   endtask

   // Back to back words with midpoints, limits and the exact lower edge of the range
   task automatic t_lanes();
      mode = 2'h1;
      push(64'h7FFF_8000_0003_0001, 64'h7FFF_7FFF_0080_0080);
      push(64'hFFFF_FFFD_0100_0180, 64'h0080_0080_FF00_0200);
      push(64'h0123_4000_C000_00C1, 64'h0101_0200_0200_00FF);
      push(64'h0001_0001_0001_7FFF, 64'h0100_0100_0100_7FFF);
      idle();
      drain();
   endtask

   // Stalled sink: pipe of 3 plus buffer of 8 must fill, then refuse
   task automatic t_backpressure();
      int taken;
      taken = 0;
      mode = 2'h2;
      @(negedge mclk);
      for (int i = 0; i < 16; i++) begin
         a = {4{16'h0040 + 16'(i)}};
         b = 64'h0200_FE00_0180_0100;
         valid = 1'b1;
         if (in_ready !== 1'b1) break;
         expect_word(a, b);
         taken++;
         @(posedge mclk);
         @(negedge mclk);
      end
      repeat (3) @(negedge mclk);
      check_bit(in_ready, 1'b0);
      check_word(OW'(taken), OW'(11));
      valid = 1'b0;
      mode = 2'h1;
      drain();
   endtask

   // Enable low with a willing sink: output and queued words must hold
   task automatic t_enable();
      logic [OW-1:0] held;
      mode = 2'h2;
      push(64'h0200_0300_FF00_0080, 64'h0100_0100_0100_0180);
      push(64'h0111_0222_0333_0444, 64'h0100_0200_0080_0040);
      // Two more, so one word is still queued in the buffer while disabled
      push(64'h0040_0040_0040_0040, 64'h0100_0200_0300_0400);
      push(64'h0081_0082_0083_0084, 64'h0180_0180_0180_0180);
      idle();
      repeat (6) @(negedge mclk);
      held = prod;
      check_bit(out_valid, 1'b1);
      en = 1'b0;
      mode = 2'h0;
      repeat (6) begin
         @(negedge mclk);
         check_bit(out_valid, 1'b1);
         check_word(prod, held);
      end
      en = 1'b1;
      drain();
   endtask

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Cuts a hang; the tests need well under 2000 cycles
   initial begin
      #1000000;
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      t_latency();
      t_lanes();
      t_backpressure();
      t_enable();
      print_verdict();
   end
endmodule

/* sim/vrm_sink_model.sv */
// Downstream model for the multiplier's product stream.
// Assumes one clock; ready changes on the falling edge only.
`timescale 1ns/1ns
module vrm_sink_model #(
   parameter int W = 64
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Product stream
   input wire logic i_en,
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   // Pacing: 0 prompt, 1 every other cycle, 2 stalled
   input wire logic [1:0] i_mode
);
   logic [W-1:0] got[$];
   logic phase_r = 1'b0;
   logic [1:0] mode_r = 2'h0;

   initial o_ready = 1'b0;

   // Mode is taken on the rising edge, so a bench change on the falling edge cannot race
   always @(posedge i_mclk) begin
      mode_r <= i_mode;
   end

   // Ready pattern; a slow sink exposes any output that moves while held
   always @(negedge i_mclk) begin
      phase_r <= ~phase_r;
      case (mode_r)
         2'h0: o_ready <= 1'b1;
         2'h1: o_ready <= phase_r;
         default: o_ready <= 1'b0;
      endcase
   end

   // Take a word only on a real advance, so frozen cycles are not counted
   always @(posedge i_mclk) begin
      if (i_rst_b && i_en && i_valid && o_ready) begin
         got.push_back(i_data);
      end
   end
endmodule
